// [hw/gmsr_mux.sv]
/*
 * gmsr_mux: five-bit output source selector, registered.
 * assumes: sources arrive already synchronised through gmsr_src_if.
 */
`timescale 1ns/1ns
module gmsr_mux (
	input wire logic clk_sys,
	input wire logic srst,
	gmsr_src_if.user_side sif,
	input wire logic [gmsr_pkg::SEL_W-1:0] sel,
	input wire logic static_level,
	output logic general_output_state
);
	import gmsr_pkg::*;

	logic gpo_r, gpo_nxt;

	// one source per code; holes drive low so the pin is never undefined
	function automatic logic pick(input logic [SEL_W-1:0] code,
		input logic [SRC_W-1:0] src, input logic lvl);
		if (code == SEL_STATIC)
			return lvl;
		else if (code == SEL_RSVD)
			return 1'b0;
		else if (code >= SEL_DNU_LO && code <= SEL_DNU_HI)
			return 1'b0;
		else
			return src[code];
	endfunction

	always_comb begin
		gpo_nxt = pick(sel, sif.src, static_level);
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			gpo_r <= 1'b0;
		else
			gpo_r <= gpo_nxt;
	end

	assign general_output_state = gpo_r;
endmodule // gmsr_mux

// [hw/gmsr_pkg.sv]
/*
 * gmsr_pkg: register offsets, field positions, reset values and output
 * source codes of the output mux and status readback block.
 * assumes: the serial port core presents 6-bit register indexes and
 * 24-bit data words on the system clock.
 */
package gmsr_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int SRC_W = 32;
	localparam int SEL_W = 5;
	localparam int BAND_W = 8;
	localparam int ERR_W = 20;
	localparam int STAT_W = 2;

	// register indexes
	localparam logic [ADDR_W-1:0] ADDR_OUT_MUX_CFG = 6'h0f;
	localparam logic [ADDR_W-1:0] ADDR_VCO_BAND = 6'h10;
	localparam logic [ADDR_W-1:0] ADDR_TUNE_ERR = 6'h11;
	localparam logic [ADDR_W-1:0] ADDR_LOCK_STAT = 6'h12;
	localparam logic [ADDR_W-1:0] ADDR_SELF_TEST = 6'h13;

	// output_mux_config field positions
	localparam int SEL_LSB = 0;
	localparam int STATIC_TEST_BIT = 5;
	localparam int FORCE_ONLY_BIT = 6;
	localparam int DRV_ALWAYS_BIT = 7;
	localparam int HIGH_DIS_BIT = 8;
	localparam int LOW_DIS_BIT = 9;

	// readback field positions
	localparam int BUSY_BIT = 8;
	localparam int GPO_STATE_BIT = 0;
	localparam int LOCK_BIT = 1;

	// reset values
	localparam logic [DATA_W-1:0] RST_OUT_MUX_CFG = 24'h000001;
	localparam logic [BAND_W-1:0] RST_VCO_BAND = 8'h20;
	localparam logic [ERR_W-1:0] RST_TUNE_ERR = 20'h7ffff;
	localparam logic [STAT_W-1:0] RST_LOCK_STAT = 2'h0;
	localparam logic [DATA_W-1:0] SELF_TEST_WORD = 24'h001259;

	// output source codes
	localparam logic [SEL_W-1:0] SEL_STATIC = 5'h00;
	localparam logic [SEL_W-1:0] SEL_RSVD = 5'h07;
	localparam logic [SEL_W-1:0] SEL_DNU_LO = 5'h1a;
	localparam logic [SEL_W-1:0] SEL_DNU_HI = 5'h1d;

	typedef enum logic [2:0] {
		GMSR_IDLE = 3'b001,
		GMSR_CAL = 3'b010,
		GMSR_CAPT = 3'b100
	} gmsr_cal_st_t;
endpackage

// [hw/gmsr_src_if.sv]
/*
 * gmsr_src_if: synchronised internal sources and status levels passed
 * from the synchroniser to the main block and the output mux.
 * assumes: one system clock.
 */
`timescale 1ns/1ns
interface gmsr_src_if;
	logic [gmsr_pkg::SRC_W-1:0] src;
	logic busy;
	logic lock;
	modport sync_side (output src, output busy, output lock);
	modport user_side (input src, input busy, input lock);
endinterface // gmsr_src_if

// [hw/gmsr_sync.sv]
/*
 * gmsr_sync: two-stage synchronisers for every internal source that
 * comes from the reference, modulator or calibration domains.
 * assumes: sources are levels or slow enough to survive sampling.
 */
`timescale 1ns/1ns
module gmsr_sync (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [gmsr_pkg::SRC_W-1:0] src_raw,
	input wire logic busy_raw,
	input wire logic lock_raw,
	gmsr_src_if.sync_side sif
);
	import gmsr_pkg::*;

	logic [SRC_W+1:0] meta_r, meta_nxt;
	logic [SRC_W+1:0] stab_r, stab_nxt;

	// first stage feeds only the second stage
	always_comb begin
		meta_nxt = {busy_raw, lock_raw, src_raw};
		stab_nxt = meta_r;
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			meta_r <= '0;
			stab_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			stab_r <= stab_nxt;
		end
	end

	assign sif.src = stab_r[SRC_W-1:0];
	assign sif.lock = stab_r[SRC_W];
	assign sif.busy = stab_r[SRC_W+1];
endmodule // gmsr_sync

// [hw/gmsr_top.sv]
/*
 * gmsr_top: output mux configuration and status readback registers of
 * the synthesizer serial control port, plus the data-out pin control.
 * assumes: the serial port core gives one-cycle write and read strobes
 * with a register index, and tells when a serial read cycle is running;
 * the data-out enable bit lives in another register and arrives here.
 */
// What this block does
// - data-out pin carries the source picked by the 5-bit selector when enabled
// - code 0 drives the static test level bit 5
// - codes 1 to 3 give lock result, lock trigger, lock window
// - codes 8 to 11 give reference buffer, ref divider, VCO divider, modulator clock
// - codes 12 to 15 give auxiliary clock, serial clock, enable, data-out
// - codes 16 to 19 give detector down, up, modulator delay and core clocks
// - codes 20 to 23 give the three autostrobes and serial latch enable
// - codes 24, 25, 30, 31 give divider sync reset, seed load, buffer enable, reset
// - force-output-only 0 automuxes read data and source; 1 gives source only
// - driver-always-on 0 drives pin only in read cycles; 1 drives always
// - high-drive disable turns off the pull-high transistor
// - low-drive disable turns off the pull-low transistor
// - read-only 8-bit VCO band chosen by calibration, 0 highest frequency
// - band value is invalid while the busy flag at bit 8 is set
// - band readback follows calibration results only, never manual settings
// - busy flag reads 1 while calibration searches, else 0
// - tune error reads as 19-bit magnitude plus sign in bit 19
// - status register gives output state bit 0 and lock bit 1, resets zero
// - output configuration resets to 0x000001, lock result selected
`timescale 1ns/1ns
module gmsr_top (
	input wire logic clk_sys,
	input wire logic srst,
	// register access from the serial port core
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [gmsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [gmsr_pkg::DATA_W-1:0] reg_wdata,
	output logic [gmsr_pkg::DATA_W-1:0] reg_rdata,
	// serial port state
	input wire logic spi_read_active,
	input wire logic spi_read_bit,
	input wire logic sdo_enable,
	// internal sources and calibration results
	input wire logic [gmsr_pkg::SRC_W-1:0] src_raw,
	input wire logic cal_busy_raw,
	input wire logic lock_raw,
	input wire logic [gmsr_pkg::BAND_W-1:0] cal_band,
	input wire logic [gmsr_pkg::ERR_W-1:0] cal_error,
	// data-out pin
	output logic sdo_out,
	output logic sdo_oe_n,
	output logic sdo_high_en,
	output logic sdo_low_en
);
	import gmsr_pkg::*;

	gmsr_src_if sif ();

	logic general_output_state;
	logic [DATA_W-1:0] cfg_r, cfg_nxt;
	logic [BAND_W-1:0] band_r, band_nxt;
	logic [ERR_W-1:0] err_r, err_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	gmsr_cal_st_t cal_st_r, cal_st_nxt;
	logic sdo_out_r, sdo_out_nxt;
	logic sdo_oe_n_r, sdo_oe_n_nxt;
	logic high_en_r, high_en_nxt;
	logic low_en_r, low_en_nxt;
	logic drive_on;

	////////////////////////////////////////////////////////////////////////
	// synchronisers and source mux

	// every outside source passes two flops before the mux reads it
	gmsr_sync u_sync (
		.clk_sys(clk_sys),
		.srst(srst),
		.src_raw(src_raw),
		.busy_raw(cal_busy_raw),
		.lock_raw(lock_raw),
		.sif(sif.sync_side)
	);

	gmsr_mux u_mux (
		.clk_sys(clk_sys),
		.srst(srst),
		.sif(sif.user_side),
		.sel(cfg_r[SEL_LSB +: SEL_W]),
		.static_level(cfg_r[STATIC_TEST_BIT]),
		.general_output_state(general_output_state)
	);

	////////////////////////////////////////////////////////////////////////
	// output configuration register

	// codes 7 and 26..29 are stored as written; the mux grounds them
	// rather than refusing the write, so readback matches what was sent
	always_comb begin
		cfg_nxt = cfg_r;
		if (reg_wr && reg_addr == ADDR_OUT_MUX_CFG)
			cfg_nxt = reg_wdata;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			cfg_r <= RST_OUT_MUX_CFG;
		else
			cfg_r <= cfg_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// calibration result capture

	// results are taken only when the synchronised busy flag falls, so the
	// band and error words are stable when sampled; manual band writes
	// elsewhere never reach this register
	always_comb begin
		cal_st_nxt = cal_st_r;
		band_nxt = band_r;
		err_nxt = err_r;
		unique case (cal_st_r)
			GMSR_IDLE: begin
				if (sif.busy)
					cal_st_nxt = GMSR_CAL;
			end
			GMSR_CAL: begin
				if (!sif.busy)
					cal_st_nxt = GMSR_CAPT;
			end
			GMSR_CAPT: begin
				band_nxt = cal_band;
				err_nxt = cal_error;
				cal_st_nxt = sif.busy ? GMSR_CAL : GMSR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cal_st_r <= GMSR_IDLE;
			band_r <= RST_VCO_BAND;
			err_r <= RST_TUNE_ERR;
		end else begin
			cal_st_r <= cal_st_nxt;
			band_r <= band_nxt;
			err_r <= err_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register readback

	// unmapped indexes read zero; bits above each field read zero except in the config word, which reads back all 24 bits as written
	function automatic logic [DATA_W-1:0] read_word(
		input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] w;
		w = '0;
		unique case (a)
			ADDR_OUT_MUX_CFG: w = cfg_r;
			ADDR_VCO_BAND: begin
				w[BAND_W-1:0] = band_r;
				w[BUSY_BIT] = sif.busy;
			end
			ADDR_TUNE_ERR: w[ERR_W-1:0] = err_r;
			ADDR_LOCK_STAT: begin
				w[GPO_STATE_BIT] = general_output_state;
				w[LOCK_BIT] = sif.lock;
			end
			ADDR_SELF_TEST: w = SELF_TEST_WORD;
			default: w = '0;
		endcase
		return w;
	endfunction

	always_comb begin
		rdata_nxt = rdata_r;
		if (reg_rd)
			rdata_nxt = read_word(reg_addr);
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			rdata_r <= '0;
		else
			rdata_r <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// data-out pin

	// driver on only with the enable bit and either always-on or a read
	// cycle; without always-on a serial-mode host would see the pin float
	// between reads, hence software is expected to set it there
	assign drive_on = sdo_enable &&
		(cfg_r[DRV_ALWAYS_BIT] || spi_read_active);

	always_comb begin
		if (cfg_r[FORCE_ONLY_BIT] || !spi_read_active)
			sdo_out_nxt = general_output_state;
		else
			sdo_out_nxt = spi_read_bit;
		sdo_oe_n_nxt = !drive_on;
		high_en_nxt = drive_on && !cfg_r[HIGH_DIS_BIT];
		low_en_nxt = drive_on && !cfg_r[LOW_DIS_BIT];
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sdo_out_r <= 1'b0;
			sdo_oe_n_r <= 1'b1;
			high_en_r <= 1'b0;
			low_en_r <= 1'b0;
		end else begin
			sdo_out_r <= sdo_out_nxt;
			sdo_oe_n_r <= sdo_oe_n_nxt;
			high_en_r <= high_en_nxt;
			low_en_r <= low_en_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign sdo_out = sdo_out_r;
	assign sdo_oe_n = sdo_oe_n_r;
	assign sdo_high_en = high_en_r;
	assign sdo_low_en = low_en_r;
endmodule // gmsr_top

// [sim/gmsr_chk_sva.sv]
/* gmsr_chk: port checks of the output mux and readback block.
 * assumes: bound into gmsr_top, one clock, synchronous srst. */
`timescale 1ns/1ns
module gmsr_chk (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [gmsr_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [gmsr_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [gmsr_pkg::DATA_W-1:0] reg_rdata,
	input wire logic spi_read_active,
	input wire logic spi_read_bit,
	input wire logic sdo_enable,
	input wire logic sdo_out,
	input wire logic sdo_oe_n,
	input wire logic sdo_high_en,
	input wire logic sdo_low_en
);
	import gmsr_pkg::*;
	logic [DATA_W-1:0] cfg_r, cfg_nxt;
	logic rd_r;
	////////////////////////////////////////////////////////////////
	// shadow of the config word, known only through writes
	always_comb begin
		cfg_nxt = cfg_r;
		if (srst) begin
			cfg_nxt = RST_OUT_MUX_CFG;
		end else if (reg_wr && reg_addr == ADDR_OUT_MUX_CFG) begin
			cfg_nxt = reg_wdata;
		end
	end
	always_ff @(posedge clk_sys) begin
		cfg_r <= cfg_nxt;
	end
	assign rd_r = reg_rd;
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// pin checks skip the edge after reset, inputs were not yet seen
	pin_enable_a: assert property (!$past(srst) |->
		sdo_oe_n == !($past(sdo_enable) && ($past(cfg_r[DRV_ALWAYS_BIT])
		|| $past(spi_read_active)))) else $error("pin enable wrong");
	high_drive_a: assert property (!$past(srst) && !sdo_oe_n |->
		sdo_high_en == !$past(cfg_r[HIGH_DIS_BIT])) else $error("high drive");
	low_drive_a: assert property (!$past(srst) && !sdo_oe_n |->
		sdo_low_en == !$past(cfg_r[LOW_DIS_BIT])) else $error("low drive");
	read_mux_a: assert property (!$past(srst) &&
		!$past(cfg_r[FORCE_ONLY_BIT]) && $past(spi_read_active) |->
		sdo_out == $past(spi_read_bit)) else $error("read data path");
	cfg_readback_a: assert property (rd_r &&
		reg_addr == ADDR_OUT_MUX_CFG |=> reg_rdata == $past(cfg_r))
		else $error("config readback");
	self_test_a: assert property (rd_r && reg_addr == ADDR_SELF_TEST
		|=> reg_rdata == SELF_TEST_WORD) else $error("self test word");
	unmapped_read_a: assert property (rd_r &&
		(reg_addr < ADDR_OUT_MUX_CFG || reg_addr > ADDR_SELF_TEST)
		|=> reg_rdata == '0) else $error("unmapped read");
	status_upper_a: assert property (rd_r &&
		reg_addr == ADDR_LOCK_STAT |=> reg_rdata[23:2] == '0)
		else $error("status upper bits");
	error_upper_a: assert property (rd_r &&
		reg_addr == ADDR_TUNE_ERR |=> reg_rdata[23:20] == '0)
		else $error("error upper bits");
	cover property (rd_r && reg_addr == ADDR_SELF_TEST);
	cover property (!sdo_oe_n && spi_read_active);
	cover property (reg_wr && reg_addr == ADDR_OUT_MUX_CFG);
endmodule // gmsr_chk

bind gmsr_top gmsr_chk u_chk (.clk_sys, .srst, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .spi_read_active, .spi_read_bit,
	.sdo_enable, .sdo_out, .sdo_oe_n, .sdo_high_en, .sdo_low_en);

// [sim/gmsr_host.sv]
/* gmsr_host: serial host side, runs an eight-bit read cycle on go.
 * assumes: go is one clk_sys cycle, bits leave msb first. */
`timescale 1ns/1ns
module gmsr_host (
	input wire logic clk_sys,
	input wire logic go,
	input wire logic [7:0] pat,
	output logic spi_read_active,
	output logic spi_read_bit
);
	logic [3:0] cnt_r = '0;
	logic [7:0] sh_r = '0;
	logic idle_r = 1'b0;
	// idle bit toggles so a stale bit never passes for read data
	always @(posedge clk_sys) begin
		idle_r <= ~idle_r;
		if (go && cnt_r == 4'h0) begin
			cnt_r <= 4'h8;
			sh_r <= pat;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
			sh_r <= {sh_r[6:0], 1'b0};
		end
	end
	assign spi_read_active = cnt_r != 4'h0;
	assign spi_read_bit = spi_read_active ? sh_r[7] : idle_r;
endmodule // gmsr_host

// [sim/gmsr_top_bench.sv]
/* gmsr_top_bench: register reads and writes plus pin checks.
 * assumes: gmsr_host plays the read side, checker is bound. */
`timescale 1ns/1ns
module gmsr_top_bench;
	import gmsr_pkg::*;
	logic clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0, go = 0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
	logic sdo_enable = 0, cal_busy_raw = 0, lock_raw = 0;
	logic [SRC_W-1:0] src_raw = '0;
	logic [BAND_W-1:0] cal_band = '0;
	logic [ERR_W-1:0] cal_error = '0;
	logic spi_read_active, spi_read_bit, sdo_out, sdo_oe_n;
	logic sdo_high_en, sdo_low_en, v, e, b;
	logic [7:0] pat = 8'ha6;
	int miscompares = 0, checks_done = 0, cyc = 0;
	gmsr_top u_dut (.clk_sys, .srst, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .spi_read_active, .spi_read_bit,
		.sdo_enable, .src_raw, .cal_busy_raw, .lock_raw, .cal_band,
		.cal_error, .sdo_out, .sdo_oe_n, .sdo_high_en, .sdo_low_en);
	gmsr_host u_host (.clk_sys, .go, .pat, .spi_read_active,
		.spi_read_bit);
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] x);
		checks_done++;
		if (s !== x) begin
			miscompares++;
			$display("mismatch at %0t: saw %h want %h", $time, s, x);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		tick(1);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
		reg_rd = 1'b1;
		reg_addr = a;
		tick(1);
		reg_rd = 1'b0;
		chk(reg_rdata, x);
		tick(1); // gap so back-to-back reads never re-raise reg_rd at once
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial forever #5 clk_sys = ~clk_sys;
	// hang guard, the run needs about 600 cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		tick(20);
		srst = 1'b0;
		rd(ADDR_OUT_MUX_CFG, RST_OUT_MUX_CFG);
		rd(ADDR_TUNE_ERR, 24'h07ffff);
		rd(ADDR_LOCK_STAT, 24'h000000);
		rd(ADDR_SELF_TEST, 24'h001259);
		rd(6'h05, 24'h000000);
		sdo_enable = 1'b1;
		// every code at both levels; the other source bits oppose
		for (int c = 0; c < 32; c++) begin
			for (int i = 0; i < 2; i++) begin
				v = i[0];
				e = v && !(c == 7 || (c >= 26 && c <= 29));
				src_raw = v ? 32'h1 << c : ~(32'h1 << c);
				if (c == 0) src_raw = {SRC_W{~v}};
				wr(ADDR_OUT_MUX_CFG, {16'h0, 2'b11, v, c[4:0]});
				tick(5);
				chk(sdo_out, e);
				rd(ADDR_LOCK_STAT, {23'h0, e});
			end
		end
		// automux with drives off and static level high, then forced
		// source (static level low) with drives on
		for (int i = 0; i < 2; i++) begin
			wr(ADDR_OUT_MUX_CFG, i ? 24'h0000c0 : 24'h000320);
			tick(3);
			chk(sdo_oe_n, i ? 1'b0 : 1'b1);
			chk(sdo_out, i ? 1'b0 : 1'b1);
			go = 1'b1;
			tick(1);
			go = 1'b0;
			repeat (8) begin
				b = spi_read_bit;
				tick(1);
				chk(sdo_out, i ? 1'b0 : b);
				chk(sdo_oe_n, 1'b0);
				chk({sdo_high_en, sdo_low_en}, {2{i[0]}});
			end
		end
		sdo_enable = 1'b0;
		tick(2);
		chk(sdo_oe_n, 1'b1);
		// results held while busy, taken once it falls
		cal_busy_raw = 1'b1;
		cal_band = 8'hff;
		cal_error = 20'h80001;
		tick(4);
		rd(ADDR_VCO_BAND, 24'h000100 | 24'(RST_VCO_BAND));
		cal_busy_raw = 1'b0;
		lock_raw = 1'b1;
		tick(8);
		rd(ADDR_VCO_BAND, 24'h0000ff);
		rd(ADDR_TUNE_ERR, 24'h080001);
		rd(ADDR_LOCK_STAT, 24'h000002);
		wr(ADDR_OUT_MUX_CFG, 24'habc3ff);
		rd(ADDR_OUT_MUX_CFG, 24'habc3ff);
		finish_test();
	end
endmodule // gmsr_top_bench
